// ===== tb/owd_debug_port_properties.sv
// Port-level assertions for the one-wire debug port.
`timescale 1ns/1ps
`default_nettype none
`include "owd_defs.vh"
module owd_port_chk
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // APB request
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  // Debug line and system side
  input wire logic       dbgLineIn,
  input wire logic       dbgLineOe,
  input wire logic       stopMode,
  input wire logic       readProtect,
  input wire logic       cpuFetchStop,
  input wire logic       cpuHaltExit,
  input wire logic       wdtRefresh,
  input wire logic       cpuLoopBrk,
  input wire logic       dbgCmdEn,
  input wire logic       sysResetReq
);
  // A control write that is allowed to clear the debug flag.
  wire         ctrlClr = psel && penable && pwrite && !readProtect
                         && paddr == `OWD_OFS_CTRL;
  logic [13:0] oeRun_r;

  // Length of the current run of the device pulling the line low.
  always_ff @(posedge ref_clk)
    if (!rst_b || !dbgLineOe)
      oeRun_r <= 14'h0000;
    else if (oeRun_r != 14'h3FFF)
      oeRun_r <= oeRun_r + 14'h0001;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // Line held low for several cycles while stopped.
  sequence seqStopLow;
    (stopMode && !dbgLineIn) [*4];
  endsequence

  // Reset has just been released.
  sequence seqOutOfReset;
    $rose(rst_b);
  endsequence

  AST_HALT_WDT:
    assert property (cpuHaltExit == cpuFetchStop && wdtRefresh == cpuFetchStop)
    else $error("Halt exit or watchdog refresh differs from debug mode.");
  AST_CMD_GATE:
    assert property (dbgCmdEn == (cpuFetchStop && !cpuLoopBrk))
    else $error("Command enable wrong for debug or loop state.");
  AST_STOP_RESET:
    assert property (seqStopLow |-> sysResetReq)
    else $error("No system reset for line low in stop mode.");
  AST_RESET_CAUSE:
    assert property (sysResetReq |-> stopMode && !$past(dbgLineIn, 2))
    else $error("System reset without stop mode and low line.");
  AST_DBG_EXIT:
    assert property ($fell(cpuFetchStop) |-> $past(ctrlClr) || !$past(rst_b))
    else $error("Debug mode left without a control write.");
  AST_RP_HOLD:
    assert property (readProtect && cpuFetchStop |=> cpuFetchStop)
    else $error("Debug mode cleared under read protect.");
  AST_IDLE_AFTER_RESET:
    assert property (seqOutOfReset |-> !dbgLineOe [*8])
    else $error("Line pulled right after reset.");
  AST_BREAK_LEN:
    assert property (oeRun_r <= 14'h1200)
    else $error("Device held the line low too long.");
endmodule // owd_port_chk
`default_nettype wire

// ===== tb/owd_host_model.sv
// Behavioural debug host on the shared open-drain line.
`timescale 1ns/1ps
`default_nettype none
module owd_host_model
(
  // Clock and line
  input  wire logic ref_clk,
  input  wire logic lineLevel,
  // Line pull-down request
  output var logic  hostPull
);
  // Sixteen clocks a bit, slower than a clock over eight.
  int bitCyc = 16;

  // The line is released until a scenario asks for more.
  initial
    hostPull = 1'h0;

  // Pull or release the line for a number of clocks; breaks too.
  task automatic hold(input logic low, input int n);
    hostPull <= low;
    repeat (n) @(posedge ref_clk);
  endtask

  // Send one character with a chosen stop level, once the line is free.
  task automatic send_byte(input logic [7:0] b, input logic stopBit);
    wait (lineLevel === 1'h1);
    @(posedge ref_clk);
    hold(1'h1, bitCyc);
    for (int i = 0; i < 8; i++)
      hold(!b[i], bitCyc);
    hold(!stopBit, bitCyc);
    hold(1'h0, bitCyc);
  endtask

  // Receive one character, sampling each bit in its middle.
  task automatic recv_byte(output logic [7:0] b, output logic stopOk);
    wait (lineLevel === 1'h0);
    repeat (bitCyc * 3 / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = lineLevel;
      repeat (bitCyc) @(posedge ref_clk);
    end
    stopOk = lineLevel;
  endtask
endmodule // owd_host_model
`default_nettype wire

// ===== tb/test_owd_debug_port.sv
// Self-checking bench for the one-wire debug port.
`timescale 1ns/1ps
`default_nettype none
`include "owd_defs.vh"
module test_owd_debug_port;
  // Design inputs.
  logic             ref_clk, rst_b, psel, penable, pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic             brkDecode, stopMode, readProtect;
  // Design outputs and the shared line.
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, dbgLineOut, dbgLineOe;
  wire logic        cpuFetchStop, cpuHaltExit, wdtRefresh, cpuLoopBrk;
  wire logic        dbgCmdEn, sysResetReq, hostPull, lineLevel;
  // Bench state.
  int               fails, nChecks, cyc, oeRun;
  logic [31:0]      rd;
  logic             er, rs;
  logic [7:0]       rb;

  // Pulled-up line: low while either side pulls it.
  assign lineLevel = !((dbgLineOe && !dbgLineOut) || hostPull);

  owd_debug_port owd_debug_port_i
  (
    .ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .dbgLineIn(lineLevel), .dbgLineOut,
    .dbgLineOe, .brkDecode, .stopMode, .readProtect, .cpuFetchStop,
    .cpuHaltExit, .wdtRefresh, .cpuLoopBrk, .dbgCmdEn, .sysResetReq
  );
  owd_host_model owd_host_model_i (.ref_clk, .lineLevel, .hostPull);

  // Clock at 250 MHz.
  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Cycle ceiling, and the run length of the device pulling the line.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    oeRun <= dbgLineOe ? oeRun + 1 : 0;
    if (cyc == 60000)
    begin
      fails++;
      print_verdict();
    end
  end

  task print_verdict;
    if (fails == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
      @(posedge ref_clk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // One breakpoint decode pulse, then a status read.
  task brk_pulse;
    @(posedge ref_clk);
    brkDecode <= 1'h1;
    @(posedge ref_clk);
    brkDecode <= 1'h0;
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
  endtask

  // Calibrate on an 80H character and check the measured period.
  task cal;
    owd_host_model_i.send_byte(8'h80, 1'h1);
    apb(1'h0, `OWD_OFS_BAUD, 32'h0);
    chk(rd, 32'h10);
  endtask

  // Wait out an error break, check it, clear it and recalibrate.
  task expect_break(input int bitPos);
    do
      @(posedge ref_clk);
    while (oeRun < 100 || dbgLineOe);
    chk(oeRun, 4096);
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd[bitPos], 1'h1);
    chk(rd[`OWD_ST_LOCKED], 1'h0);
    apb(1'h1, `OWD_OFS_STAT, 32'h700);
    cal();
  endtask

  // Reset values and an unmapped address.
  task t_regs;
    apb(1'h0, `OWD_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 8'h14, 32'hFFFFFFFF);
    chk(er, 1'h1);
    apb(1'h0, 8'h14, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Calibration, one received and one sent character.
  task t_link;
    cal();
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd[`OWD_ST_LOCKED], 1'h1);
    owd_host_model_i.send_byte(8'hA5, 1'h1);
    apb(1'h0, `OWD_OFS_RXD, 32'h0);
    chk(rd, 32'hA5);
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd[10:8], 3'h0);
    apb(1'h1, `OWD_OFS_TXD, 32'h3C);
    owd_host_model_i.recv_byte(rb, rs);
    chk(rb, 8'h3C);
    chk(rs, 1'h1);
    repeat (16) @(posedge ref_clk);
    chk(dbgLineOe, 1'h0);
  endtask

  // Framing error, host break in debug mode, and a collision.
  task t_errs;
    owd_host_model_i.send_byte(8'h55, 1'h0);
    expect_break(`OWD_ST_ERRFRM);
    apb(1'h1, `OWD_OFS_CTRL, 32'h80);
    owd_host_model_i.hold(1'h1, 200);
    owd_host_model_i.hold(1'h0, 1);
    expect_break(`OWD_ST_ERRBRK);
    apb(1'h0, `OWD_OFS_CTRL, 32'h0);
    chk(rd, 32'h80);
    apb(1'h1, `OWD_OFS_TXD, 32'hFF);
    wait (dbgLineOe === 1'h1);
    repeat (20) @(posedge ref_clk);
    owd_host_model_i.hold(1'h1, 24);
    owd_host_model_i.hold(1'h0, 1);
    expect_break(`OWD_ST_ERRCOL);
  endtask

  // Debug flag kept under read protect, then cleared.
  task t_debug;
    readProtect <= 1'h1;
    apb(1'h1, `OWD_OFS_CTRL, 32'h0);
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd[7:5], 3'h5);
    chk({cpuFetchStop, wdtRefresh, dbgCmdEn}, 3'h7);
    readProtect <= 1'h0;
    apb(1'h1, `OWD_OFS_CTRL, 32'h0);
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd[7], 1'h0);
    chk(cpuFetchStop, 1'h0);
  endtask

  // Breakpoints: ignored, looping, loop release, halting.
  task t_brkpt;
    brk_pulse();
    chk(rd[7:6], 2'h0);
    apb(1'h1, `OWD_OFS_CTRL, 32'h60);
    brk_pulse();
    chk(rd[7:6], 2'h1);
    chk(dbgCmdEn, 1'h0);
    apb(1'h1, `OWD_OFS_CTRL, 32'h40);
    brk_pulse();
    chk(rd[7:6], 2'h2);
    apb(1'h1, `OWD_OFS_CTRL, 32'h0);
    apb(1'h1, `OWD_OFS_CTRL, 32'h40);
    brk_pulse();
    chk(rd[7:6], 2'h2);
  endtask

  // Line low outside and inside stop mode, then line low at reset.
  task t_sys;
    for (int s = 0; s < 2; s++)
    begin
      stopMode <= s[0];
      owd_host_model_i.hold(1'h1, 8);
      chk(sysResetReq, s[0]);
      owd_host_model_i.hold(1'h0, 400);
    end
    stopMode <= 1'h0;
    owd_host_model_i.hold(1'h1, 1);
    rst_b <= 1'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    owd_host_model_i.hold(1'h1, 4);
    apb(1'h0, `OWD_OFS_STAT, 32'h0);
    chk(rd[7], 1'h1);
    owd_host_model_i.hold(1'h0, 1);
  endtask

  // Drive inputs, reset, run the scenarios and report.
  initial
  begin
    {psel, penable, pwrite, brkDecode, stopMode, readProtect} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rst_b = 1'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    t_regs();
    t_link();
    t_errs();
    t_debug();
    t_brkpt();
    t_sys();
    print_verdict();
  end
endmodule // test_owd_debug_port

bind owd_debug_port owd_port_chk owd_port_chk_i
(
  .ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .dbgLineIn,
  .dbgLineOe, .stopMode, .readProtect, .cpuFetchStop, .cpuHaltExit,
  .wdtRefresh, .cpuLoopBrk, .dbgCmdEn, .sysResetReq
);
`default_nettype wire

// ===== verilog/owd_debug_port.v
// One-wire debug port: auto-baud serial link, debug mode and breakpoints.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module owd_debug_port
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // APB slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Debug line, open drain
  input  wire        dbgLineIn,
  output wire        dbgLineOut,
  output wire        dbgLineOe,
  // CPU and system side
  input  wire        brkDecode,
  input  wire        stopMode,
  input  wire        readProtect,
  output wire        cpuFetchStop,
  output wire        cpuHaltExit,
  output wire        wdtRefresh,
  output wire        cpuLoopBrk,
  output wire        dbgCmdEn,
  output wire        sysResetReq
);

`include "owd_defs.vh"

  // --------------------------------------------------------------------
  // Link states
  // --------------------------------------------------------------------
  localparam [2:0] ST_CAL   = 3'h0;
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_RX    = 3'h2;
  localparam [2:0] ST_TX    = 3'h3;
  localparam [2:0] ST_SBRK  = 3'h4;
  localparam [2:0] ST_WAITH = 3'h5;

  // --------------------------------------------------------------------
  // Register decode, shared by read and write paths
  // --------------------------------------------------------------------
  function [2:0] owdDecode;
    input [7:0] adr;
    begin
      case (adr)
        `OWD_OFS_CTRL: owdDecode = 3'h1;
        `OWD_OFS_STAT: owdDecode = 3'h2;
        `OWD_OFS_RXD:  owdDecode = 3'h3;
        `OWD_OFS_TXD:  owdDecode = 3'h4;
        `OWD_OFS_BAUD: owdDecode = 3'h5;
        default:       owdDecode = 3'h0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg        lineM_r;
  reg        lineS_r;
  reg        lineD_r;
  reg [1:0]  postRst_r;
  reg [2:0]  state_r;
  reg [9:0]  bitPer_r;
  reg        locked_r;
  reg [12:0] cnt_r;
  reg [3:0]  bitCnt_r;
  reg [12:0] lowCnt_r;
  reg [9:0]  txShift_r;
  reg [7:0]  rxShift_r;
  reg [7:0]  rxData_r;
  reg        rxValid_r;
  reg [7:0]  txData_r;
  reg        txPend_r;
  reg        debug_mode_flag_r;
  reg        brkEn_r;
  reg        brkLoop_r;
  reg        looping_r;
  reg        errBrk_r;
  reg        errFrm_r;
  reg        errCol_r;
  reg        drive_r;
  wire [2:0]  sel;
  wire        apbWr;
  wire        apbRd;
  wire        ctlWr;
  wire [9:0]  halfPer;
  wire [12:0] brkLim;
  wire        hostBrk;
  wire        rise;
  wire        fall;
  wire        midBit;
  wire        endBit;
  wire        colNow;
  wire        rxDone;
  wire        frmErr;
  wire        rxRead;
  wire        brkHalt;
  wire        brkLoopHit;
  wire        brkResume;

  // --------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped offsets
  // --------------------------------------------------------------------
  assign sel     = owdDecode(paddr);
  assign apbWr   = psel & penable & pwrite;
  assign apbRd   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel == 3'h0);
  assign ctlWr   = apbWr & (sel == 3'h1);
  assign rxRead  = apbRd & (sel == 3'h3);

  // Read data is captured in the setup phase so it comes from a register.
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
    begin
      case (sel)
        3'h1: prdata <= {24'h000000, debug_mode_flag_r, brkEn_r, brkLoop_r,
                         5'h00};
        3'h2: prdata <= {21'h000000, errBrk_r, errFrm_r, errCol_r,
                         debug_mode_flag_r, looping_r, readProtect, locked_r,
                         rxValid_r, txPend_r, 2'h0};
        3'h3: prdata <= {24'h000000, rxData_r};
        3'h5: prdata <= {22'h000000, bitPer_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Line synchroniser; the first stage feeds only the second
  // --------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      lineM_r <= 1'b1;
      lineS_r <= 1'b1;
      lineD_r <= 1'b1;
    end
    else
    begin
      lineM_r <= dbgLineIn;
      lineS_r <= lineM_r;
      lineD_r <= lineS_r;
    end
  end

  assign rise = lineS_r & ~lineD_r;
  assign fall = ~lineS_r & lineD_r;

  // --------------------------------------------------------------------
  // Bit timing and line drive
  // --------------------------------------------------------------------
  assign halfPer = {1'b0, bitPer_r[9:1]};
  assign midBit  = (cnt_r[9:0] == halfPer);
  assign endBit  = (cnt_r == 13'h0000);
  // Nine bit periods of low, or the slowest rate's nine before lock.
  assign brkLim  = locked_r ?
                   ({bitPer_r, 3'h0} + {3'h0, bitPer_r}) :
                   ({`OWD_MAX_DIV, 3'h0} + {3'h0, `OWD_MAX_DIV});
  assign hostBrk = (lowCnt_r >= brkLim) &&
                   (state_r != ST_SBRK) && (state_r != ST_WAITH);
  // A one we release must read back high at mid bit.
  assign colNow  = (state_r == ST_TX) & midBit & txShift_r[0]
                   & ~lineS_r;
  assign rxDone  = (state_r == ST_RX) & midBit & (bitCnt_r == 4'h9);
  assign frmErr  = rxDone & ~lineS_r;

  // Open drain: output is always low, enable pulls the line.
  assign dbgLineOut = 1'b0;
  assign dbgLineOe  = drive_r;

  // Consecutive low cycles seen while this end is not pulling the line.
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      lowCnt_r <= 13'h0000;
    else if (lineS_r | drive_r)
      lowCnt_r <= 13'h0000;
    else if (lowCnt_r != 13'h1FFF)
      lowCnt_r <= lowCnt_r + 13'h0001;
  end

  // --------------------------------------------------------------------
  // Link state machine: calibrate, receive, transmit, break, recover
  // --------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_r   <= ST_CAL;
      bitPer_r  <= `OWD_MAX_DIV;
      locked_r  <= 1'b0;
      cnt_r     <= 13'h0000;
      bitCnt_r  <= 4'h0;
      txShift_r <= 10'h3FF;
      rxShift_r <= 8'h00;
      drive_r   <= 1'b0;
    end
    else if (hostBrk | frmErr | colNow)
    begin
      // Abort whatever is in flight and answer with a break.
      state_r  <= ST_SBRK;
      cnt_r    <= `OWD_BREAK_CYC - 13'h0001;
      drive_r  <= 1'b1;
      locked_r <= 1'b0;
      bitCnt_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        ST_CAL:
        begin
          drive_r <= 1'b0;
          // The 80H character holds the line low for eight bits.
          // The low-run counter still shows the run on the rising edge,
          // so only the measured count qualifies the edge here.
          if (rise && cnt_r != 13'h0000)
          begin
            if (cnt_r[12:3] >= `OWD_MIN_DIV)
            begin
              bitPer_r <= cnt_r[12:3];
              locked_r <= 1'b1;
              state_r  <= ST_IDLE;
            end
            cnt_r <= 13'h0000;
          end
          else if (~lineS_r)
            cnt_r <= cnt_r + 13'h0001;
          else
            cnt_r <= 13'h0000;
        end
        ST_IDLE:
        begin
          drive_r  <= 1'b0;
          bitCnt_r <= 4'h0;
          if (fall)
          begin
            // Receive has priority; never send over the host.
            state_r <= ST_RX;
            cnt_r   <= {3'h0, bitPer_r} - 13'h0002;
          end
          else if (txPend_r & lineS_r)
          begin
            state_r   <= ST_TX;
            txShift_r <= {1'b1, txData_r, 1'b0};
            drive_r   <= 1'b1;
            cnt_r     <= {3'h0, bitPer_r} - 13'h0001;
          end
        end
        ST_RX:
        begin
          cnt_r <= endBit ? ({3'h0, bitPer_r} - 13'h0001) :
                            (cnt_r - 13'h0001);
          if (midBit)
          begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == 4'h0 && lineS_r)
              state_r <= ST_IDLE;
            else if (bitCnt_r != 4'h0 && bitCnt_r != 4'h9)
              rxShift_r <= {lineS_r, rxShift_r[7:1]};
            else if (bitCnt_r == 4'h9)
              state_r <= ST_IDLE;
          end
        end
        ST_TX:
        begin
          if (endBit)
          begin
            cnt_r     <= {3'h0, bitPer_r} - 13'h0001;
            bitCnt_r  <= bitCnt_r + 4'h1;
            txShift_r <= {1'b1, txShift_r[9:1]};
            drive_r   <= ~txShift_r[1];
            if (bitCnt_r == `OWD_FRAME_BITS - 4'h1)
            begin
              state_r <= ST_IDLE;
              drive_r <= 1'b0;
            end
          end
          else
            cnt_r <= cnt_r - 13'h0001;
        end
        ST_SBRK:
        begin
          if (endBit)
          begin
            drive_r <= 1'b0;
            state_r <= ST_WAITH;
          end
          else
            cnt_r <= cnt_r - 13'h0001;
        end
        ST_WAITH:
        begin
          // Held in reset until the host lets the line go high.
          drive_r   <= 1'b0;
          bitPer_r  <= `OWD_MAX_DIV;
          txShift_r <= 10'h3FF;
          rxShift_r <= 8'h00;
          cnt_r     <= 13'h0000;
          if (lineS_r)
            state_r <= ST_CAL;
        end
        default:
        begin
          state_r <= ST_CAL;
          drive_r <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Software data path and sticky error flags, set wins over clear
  // --------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rxData_r  <= 8'h00;
      rxValid_r <= 1'b0;
      txData_r  <= 8'h00;
      txPend_r  <= 1'b0;
      errBrk_r  <= 1'b0;
      errFrm_r  <= 1'b0;
      errCol_r  <= 1'b0;
    end
    else
    begin
      if (rxDone & lineS_r)
      begin
        rxData_r  <= rxShift_r;
        rxValid_r <= 1'b1;
      end
      else if (rxRead)
        rxValid_r <= 1'b0;
      // The aborted character is dropped with the rest of the command.
      if (hostBrk | frmErr | colNow | (state_r == ST_WAITH))
        txPend_r <= 1'b0;
      else if (state_r == ST_TX && endBit &&
               bitCnt_r == `OWD_FRAME_BITS - 4'h1)
        txPend_r <= 1'b0;
      else if (apbWr && sel == 3'h4 && !txPend_r)
      begin
        txData_r <= pwdata[7:0];
        txPend_r <= 1'b1;
      end
      errBrk_r <= hostBrk |
                  (errBrk_r & ~(apbWr && sel == 3'h2 &&
                                pwdata[`OWD_ST_ERRBRK]));
      errFrm_r <= frmErr |
                  (errFrm_r & ~(apbWr && sel == 3'h2 &&
                                pwdata[`OWD_ST_ERRFRM]));
      errCol_r <= colNow |
                  (errCol_r & ~(apbWr && sel == 3'h2 &&
                                pwdata[`OWD_ST_ERRCOL]));
    end
  end

  // --------------------------------------------------------------------
  // Breakpoint handling
  // --------------------------------------------------------------------
  assign brkHalt    = brkDecode & brkEn_r & ~brkLoop_r & ~debug_mode_flag_r;
  assign brkLoopHit = brkDecode & brkEn_r & brkLoop_r & ~debug_mode_flag_r;
  assign brkResume  = brkDecode & looping_r & ~brkLoop_r;

  // --------------------------------------------------------------------
  // Debug control and loop state; untouched by link breaks
  // --------------------------------------------------------------------
  // No link error term reaches this process, so a break keeps the flags.
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      debug_mode_flag_r <= 1'b0;
      brkEn_r   <= 1'b0;
      brkLoop_r <= 1'b0;
      looping_r <= 1'b0;
      postRst_r <= 2'h0;
    end
    else
    begin
      if (postRst_r != 2'h3)
        postRst_r <= postRst_r + 2'h1;
      if (postRst_r == 2'h2 && !lineS_r)
        debug_mode_flag_r <= 1'b1;
      else if (brkHalt | brkResume)
        debug_mode_flag_r <= 1'b1;
      else if (ctlWr)
        debug_mode_flag_r <= readProtect ?
                     (debug_mode_flag_r | pwdata[`OWD_CTL_DEBUG_MODE_FLAG]) :
                     pwdata[`OWD_CTL_DEBUG_MODE_FLAG];
      if (ctlWr)
      begin
        brkEn_r   <= pwdata[`OWD_CTL_BRKEN];
        brkLoop_r <= pwdata[`OWD_CTL_BRKLOOP];
      end
      if (brkResume)
        looping_r <= 1'b0;
      else if (brkLoopHit)
        looping_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // CPU and system controls
  // --------------------------------------------------------------------
  assign cpuFetchStop = debug_mode_flag_r;
  assign cpuHaltExit  = debug_mode_flag_r;
  assign wdtRefresh   = debug_mode_flag_r;
  assign cpuLoopBrk   = looping_r;
  assign dbgCmdEn     = debug_mode_flag_r & ~looping_r;
  assign sysResetReq  = stopMode & ~lineS_r;

endmodule // owd_debug_port

`default_nettype wire

// ===== verilog/owd_defs.vh
// Constants for the one-wire debug port: offsets, fields, resets, timing.
`ifndef OWD_DEFS_VH
`define OWD_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the APB side
// ----------------------------------------------------------------------
`define OWD_OFS_CTRL      8'h00
`define OWD_OFS_STAT      8'h04
`define OWD_OFS_RXD       8'h08
`define OWD_OFS_TXD       8'h0C
`define OWD_OFS_BAUD      8'h10

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define OWD_CTL_DEBUG_MODE_FLAG   7
`define OWD_CTL_BRKEN     6
`define OWD_CTL_BRKLOOP   5
`define OWD_CTL_RESET     8'h00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define OWD_ST_DEBUG_MODE_FLAG    7
`define OWD_ST_LOOPING    6
`define OWD_ST_RPROT      5
`define OWD_ST_LOCKED     4
`define OWD_ST_RXVALID    3
`define OWD_ST_TXBUSY     2
`define OWD_ST_ERRBRK     10
`define OWD_ST_ERRFRM     9
`define OWD_ST_ERRCOL     8

// ----------------------------------------------------------------------
// Timing counts in system clock cycles, and counts in bits
// ----------------------------------------------------------------------
`define OWD_BREAK_CYC     13'h1000
`define OWD_MAX_DIV       10'h200
`define OWD_MIN_DIV       10'h002
`define OWD_CAL_BITS      3
`define OWD_BREAK_BITS    13'h0009
`define OWD_FRAME_BITS    4'hA

`endif
